// >>> core/dtc_pkg.sv
// Shared constants, types and register layout of the dual timer/counter pair.
package dtc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Wishbone slave, one aligned word each.
  localparam logic [7:0] DTC_CTL_OFS = 8'h80; // Run bits and overflow flags.
  localparam logic [7:0] DTC_MODE_OFS = 8'h84; // Counter selects and mode codes.
  localparam logic [7:0] DTC_CLKDIV_OFS = 8'h8C; // Frequency selects.
  localparam logic [7:0] DTC_ALO_OFS = 8'h90; // Timer A low byte.
  localparam logic [7:0] DTC_AHI_OFS = 8'h94; // Timer A high byte.
  localparam logic [7:0] DTC_BLO_OFS = 8'h98; // Timer B low byte.
  localparam logic [7:0] DTC_BHI_OFS = 8'h9C; // Timer B high byte.
  localparam logic [7:0] DTC_IE_OFS = 8'hA8; // Interrupt enable register.
  localparam logic [7:0] DTC_IP_OFS = 8'hB8; // Interrupt priority register.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int DTC_CTL_B_FLAG = 7; // Timer B overflow flag.
  localparam int DTC_CTL_B_RUN = 6; // Timer B run bit.
  localparam int DTC_CTL_A_FLAG = 5; // Timer A overflow flag.
  localparam int DTC_CTL_A_RUN = 4; // Timer A run bit.
  localparam int DTC_MODE_B_CS = 6; // Timer B counter select.
  localparam int DTC_MODE_B_LSB = 4; // Timer B mode code, two bits.
  localparam int DTC_MODE_A_CS = 2; // Timer A counter select.
  localparam int DTC_MODE_A_LSB = 0; // Timer A mode code, two bits.
  localparam int DTC_CLKDIV_A_FS = 0; // Timer A frequency select.
  localparam int DTC_CLKDIV_B_FS = 1; // Timer B frequency select.
  localparam int DTC_IE_GLOBAL = 7; // Global interrupt enable.
  localparam int DTC_IE_B = 3; // Timer B interrupt enable.
  localparam int DTC_IE_A = 1; // Timer A interrupt enable.
  localparam int DTC_IP_B = 3; // Timer B priority.
  localparam int DTC_IP_A = 1; // Timer A priority.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks.
  localparam logic [7:0] DTC_REG_RST = 8'h00; // Every register clears at reset.
  localparam logic [7:0] DTC_MODE_MASK = 8'h77; // Bits 7 and 3 are reserved.
  localparam logic [7:0] DTC_IP_MASK = 8'h7F; // Bit 7 is reserved.
  localparam logic [1:0] DTC_CLKDIV_RST = 2'h0; // Both timers start at the slow rate.

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: the slow timer rate is the system clock divided by this count.
  localparam logic [3:0] DTC_PRESCALE_DIV = 4'hC;
  localparam logic [3:0] DTC_PRESCALE_LAST = DTC_PRESCALE_DIV - 4'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;

  // One timer's count, high byte and low byte.
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_s;

  // Result of one counting step.
  typedef struct packed {
    dtc_cnt_s cnt;
    logic ovf;
  } dtc_step_s;

endpackage : dtc_pkg

// >>> core/dtc_fall_detect.sv
// Count-pin synchroniser and falling-edge detector.
`timescale 1ns/1ps
module dtc_fall_detect
  import dtc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pin and detected edge.
  input wire logic pin_i,
  output logic fall_o
);

  logic sync1_r; // First stage, read only by the second stage.
  logic sync2_r; // Second stage, safe to use.
  logic last_r; // Previous synchronised level.
  logic fall_r; // One-cycle pulse per falling edge.

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser. Resetting high avoids a false edge when an idle-high
  // pin is first seen after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // Edge detector works only on the second stage, so one edge gives one pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      last_r <= sync2_r;
      fall_r <= last_r & ~sync2_r; // see R25
    end
  end

  assign fall_o = fall_r;

  // A pulse never lasts more than one cycle.
  chk_fall_single: assert property (@(posedge clk_i) disable iff (rst_i) // see R25
    fall_o |=> !fall_o) else $error("count pulse longer than one cycle");

endmodule : dtc_fall_detect

// >>> core/dtc_timer_pair.sv
// Dual timer/counter pair with a classic Wishbone register slave.
// Functional notes
// R1: Frequency select picks divide-by-twelve or undivided clock.
// R2: Enable bits 3 and 1 gate timer interrupts.
// R3: Priority bits 3 and 1 give high priority.
// R4: Timer A mode 0 is thirteen bits.
// R5: Timer A thirteen-bit overflow sets its flag.
// R6: Timer A pin falling edge adds one.
// R7: Timer A counts divided clock when select clear.
// R8: Timer A run resumes count without clearing.
// R9: Timer A mode 1 is full sixteen bits.
// R10: Timer A mode 2 reloads low from high.
// R11: Timer A split low byte uses timer A controls.
// R12: Split high byte uses timer B run, flag.
// R13: Split mode stops timer B's own counter.
// R14: Timer B has only three counting modes.
// R15: Timer B mode 0 is thirteen bits.
// R16: Timer B thirteen-bit overflow sets its flag.
// R17: Timer B counts pin edges or divided clock.
// R18: Timer B run resumes count without clearing.
// R19: Timer B mode 1 is full sixteen bits.
// R20: Timer B mode 2 reloads low from high.
// R21: Two mode bits choose timer A mode.
// R22: Mode register field layout as packaged.
// R23: Timer B mode code 3 halts it.
// R24: Flags set on overflow, cleared on vectoring.
// R25: Pins synchronised, one increment per falling edge.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module dtc_timer_pair
  import dtc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External count pins.
  input wire logic timer_a_count_pin_i,
  input wire logic timer_b_count_pin_i,
  // Processor vectoring acknowledges, one-cycle pulses.
  input wire logic timer_a_irq_ack_i,
  input wire logic timer_b_irq_ack_i,
  // Interrupt requests and their priority levels.
  output logic timer_a_irq_o,
  output logic timer_b_irq_o,
  output logic timer_a_irq_priority_o,
  output logic timer_b_irq_priority_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic ack_r; // Bus acknowledge, one cycle per access.
  logic [31:0] dat_r; // Captured read data.
  logic [7:0] rd_byte; // Read mux output.
  logic req; // A bus request is present.
  logic wr_go; // A write commits at this edge.
  logic wr_ctl, wr_mode, wr_clkdiv, wr_ie, wr_ip;
  logic wr_alo, wr_ahi, wr_blo, wr_bhi;
  logic [7:0] wdat; // Low byte lane of the write data.
  logic [7:0] mode_r; // Timer mode register.
  logic [1:0] clkdiv_r; // Frequency selects.
  logic [7:0] ie_r; // Interrupt enable register.
  logic [7:0] ip_r; // Interrupt priority register.
  logic run_a_r, run_b_r; // Run bits.
  logic flag_a_r, flag_b_r; // Overflow flags.
  logic [3:0] presc_r; // Divide-by-twelve counter.
  logic tick12; // One cycle in twelve.
  dtc_cnt_s cnt_a_r, cnt_b_r; // Count registers.
  dtc_cnt_s cnt_a_nxt, cnt_b_nxt;
  dtc_step_s step_a, step_b;
  dtc_mode_e mode_a, mode_b;
  logic cs_a, cs_b; // Counter selects.
  logic src_a, src_b; // Timer-mode rate ticks.
  logic fall_a, fall_b; // Synchronised pin falling edges.
  logic split; // Timer A is in split mode.
  logic inc_a, inc_ah, inc_b; // Counting strobes.
  logic ovf_a, ovf_ah, ovf_b; // Overflow events.

  ////////////////////////////////////////////////////////////////////////////////
  // One counting step for every mode. In 13-bit mode the upper three low-byte
  // bits are left alone: they read back whatever was last written there.
  function automatic dtc_step_s step_cnt(input dtc_mode_e m, input dtc_cnt_s c);
    dtc_step_s s;
    s.cnt = c;
    s.ovf = 1'b0;
    unique case (m)
      DTC_MODE_13: begin
        {s.ovf, s.cnt.hi, s.cnt.lo[4:0]} = {1'b0, c.hi, c.lo[4:0]} + 14'h0001;
      end
      DTC_MODE_16: begin
        {s.ovf, s.cnt.hi, s.cnt.lo} = {1'b0, c.hi, c.lo} + 17'h0_0001;
      end
      DTC_MODE_RELOAD: begin
        // Reload from the high byte, which itself never changes here.
        if (c.lo == 8'hFF) begin
          s.cnt.lo = c.hi;
          s.ovf = 1'b1;
        end else begin
          s.cnt.lo = c.lo + 8'h01;
        end
      end
      DTC_MODE_SPLIT: begin
        // Only the low byte counts; the high byte is a separate timer.
        {s.ovf, s.cnt.lo} = {1'b0, c.lo} + 9'h001;
      end
    endcase
    return s;
  endfunction : step_cnt

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone decode. A write commits on the edge where ack is high, which is
  // exactly the edge at which a classic master samples the acknowledge.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_r & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign wr_ctl = wr_go & (wb_adr_i[7:2] == DTC_CTL_OFS[7:2]);
  assign wr_mode = wr_go & (wb_adr_i[7:2] == DTC_MODE_OFS[7:2]);
  assign wr_clkdiv = wr_go & (wb_adr_i[7:2] == DTC_CLKDIV_OFS[7:2]);
  assign wr_ie = wr_go & (wb_adr_i[7:2] == DTC_IE_OFS[7:2]);
  assign wr_ip = wr_go & (wb_adr_i[7:2] == DTC_IP_OFS[7:2]);
  assign wr_alo = wr_go & (wb_adr_i[7:2] == DTC_ALO_OFS[7:2]);
  assign wr_ahi = wr_go & (wb_adr_i[7:2] == DTC_AHI_OFS[7:2]);
  assign wr_blo = wr_go & (wb_adr_i[7:2] == DTC_BLO_OFS[7:2]);
  assign wr_bhi = wr_go & (wb_adr_i[7:2] == DTC_BHI_OFS[7:2]);

  // Read mux; reserved bits and unmapped words read as zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i[7:2])
      DTC_CTL_OFS[7:2]: rd_byte = {flag_b_r, run_b_r, flag_a_r, run_a_r, 4'h0};
      DTC_MODE_OFS[7:2]: rd_byte = mode_r;
      DTC_CLKDIV_OFS[7:2]: rd_byte = {6'h00, clkdiv_r};
      DTC_ALO_OFS[7:2]: rd_byte = cnt_a_r.lo;
      DTC_AHI_OFS[7:2]: rd_byte = cnt_a_r.hi;
      DTC_BLO_OFS[7:2]: rd_byte = cnt_b_r.lo;
      DTC_BHI_OFS[7:2]: rd_byte = cnt_b_r.hi;
      DTC_IE_OFS[7:2]: rd_byte = ie_r;
      DTC_IP_OFS[7:2]: rd_byte = ip_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // Acknowledge one cycle after the request and capture read data with it.
  // Unmapped addresses are acknowledged too, so a master never hangs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= DTC_REG_RST;
      clkdiv_r <= DTC_CLKDIV_RST;
      ie_r <= DTC_REG_RST;
      ip_r <= DTC_REG_RST;
      run_a_r <= 1'b0;
      run_b_r <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_r <= wdat & DTC_MODE_MASK; // see R22
      end
      if (wr_clkdiv) begin
        clkdiv_r <= {wdat[DTC_CLKDIV_B_FS], wdat[DTC_CLKDIV_A_FS]};
      end
      if (wr_ie) begin
        ie_r <= wdat;
      end
      if (wr_ip) begin
        ip_r <= wdat & DTC_IP_MASK;
      end
      // Run bits only gate counting; they never touch the count itself.
      if (wr_ctl) begin
        run_a_r <= wdat[DTC_CTL_A_RUN]; // see R8
        run_b_r <= wdat[DTC_CTL_B_RUN]; // see R18
      end
    end
  end

  // Field decode of the mode register.
  assign mode_a = dtc_mode_e'(mode_r[DTC_MODE_A_LSB +: 2]); // see R21
  assign mode_b = dtc_mode_e'(mode_r[DTC_MODE_B_LSB +: 2]);
  assign cs_a = mode_r[DTC_MODE_A_CS];
  assign cs_b = mode_r[DTC_MODE_B_CS];
  assign split = (mode_a == DTC_MODE_SPLIT);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared divide-by-twelve prescaler; it runs free so both timers see the
  // same slow rate phase.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= 4'h0;
    end else if (presc_r == DTC_PRESCALE_LAST) begin
      presc_r <= 4'h0;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  assign tick12 = (presc_r == DTC_PRESCALE_LAST);
  assign src_a = clkdiv_r[0] ? 1'b1 : tick12; // see R1
  assign src_b = clkdiv_r[1] ? 1'b1 : tick12; // see R1

  ////////////////////////////////////////////////////////////////////////////////
  // Count pins.
  dtc_fall_detect u_fall_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_a_count_pin_i),
    .fall_o(fall_a)
  );

  dtc_fall_detect u_fall_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_b_count_pin_i),
    .fall_o(fall_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Counting strobes. The split high byte is timer only, at timer A's rate.
  assign inc_a = run_a_r & (cs_a ? fall_a : src_a); // see R6 R7 R11
  assign inc_ah = split & run_b_r & src_a; // see R12
  // Timer B stands still in split mode and with its own code 3.
  assign inc_b = run_b_r & ~split & (mode_b != DTC_MODE_SPLIT) // see R13 R23
    & (cs_b ? fall_b : src_b); // see R17

  // Next counts. A bus write to a byte wins over counting in that cycle.
  always_comb begin
    step_a = step_cnt(mode_a, cnt_a_r); // see R4 R9 R10
    step_b = step_cnt(mode_b, cnt_b_r); // see R14 R15 R19 R20
    cnt_a_nxt = cnt_a_r;
    cnt_b_nxt = cnt_b_r;
    if (inc_a) begin
      cnt_a_nxt = step_a.cnt;
    end
    if (inc_ah) begin
      cnt_a_nxt.hi = cnt_a_r.hi + 8'h01;
    end
    if (inc_b) begin
      cnt_b_nxt = step_b.cnt;
    end
    if (wr_alo) begin
      cnt_a_nxt.lo = wdat;
    end
    if (wr_ahi) begin
      cnt_a_nxt.hi = wdat;
    end
    if (wr_blo) begin
      cnt_b_nxt.lo = wdat;
    end
    if (wr_bhi) begin
      cnt_b_nxt.hi = wdat;
    end
  end

  assign ovf_a = inc_a & step_a.ovf; // see R5
  assign ovf_ah = inc_ah & (cnt_a_r.hi == 8'hFF);
  assign ovf_b = inc_b & step_b.ovf; // see R16

  // Count registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
    end else begin
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Overflow flags. An overflow in the same cycle as a vectoring clear or a
  // software write still leaves the flag set, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
    end else begin
      if (ovf_a) begin
        flag_a_r <= 1'b1; // see R5 R24
      end else if (wr_ctl) begin
        flag_a_r <= wdat[DTC_CTL_A_FLAG];
      end else if (timer_a_irq_ack_i) begin
        flag_a_r <= 1'b0; // see R24
      end
      if (ovf_b | ovf_ah) begin
        flag_b_r <= 1'b1; // see R12 R16 R24
      end else if (wr_ctl) begin
        flag_b_r <= wdat[DTC_CTL_B_FLAG];
      end else if (timer_b_irq_ack_i) begin
        flag_b_r <= 1'b0; // see R24
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests, gated by per-timer and global enables.
  assign timer_a_irq_o = flag_a_r & ie_r[DTC_IE_A] & ie_r[DTC_IE_GLOBAL]; // see R2
  assign timer_b_irq_o = flag_b_r & ie_r[DTC_IE_B] & ie_r[DTC_IE_GLOBAL]; // see R2
  assign timer_a_irq_priority_o = ip_r[DTC_IP_A]; // see R3
  assign timer_b_irq_priority_o = ip_r[DTC_IP_B]; // see R3

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_presc_spacing: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("prescaler period not twelve");

  chk_fast_count: assert property (@(posedge clk_i) disable iff (rst_i) // see R1 R7
    (run_a_r && !cs_a && clkdiv_r[0] && mode_a == DTC_MODE_16 && !wr_go)
    |=> ({cnt_a_r.hi, cnt_a_r.lo} == $past({cnt_a_r.hi, cnt_a_r.lo}) + 16'h0001))
    else $error("timer A fast rate not counting every cycle");

  chk_ovf_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R5
    (inc_a && mode_a == DTC_MODE_13 && cnt_a_r.hi == 8'hFF && cnt_a_r.lo[4:0] == 5'h1F)
    && !wr_go |=> flag_a_r && cnt_a_r.hi == 8'h00)
    else $error("timer A 13-bit overflow missed");

  chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    (ovf_b && !wr_go) |=> (timer_b_irq_o == (ie_r[DTC_IE_B] && ie_r[DTC_IE_GLOBAL])))
    else $error("timer B request not gated by enables");

  chk_prio_write: assert property (@(posedge clk_i) disable iff (rst_i) // see R3
    wr_ip |=> (timer_a_irq_priority_o == $past(wdat[DTC_IP_A])))
    else $error("timer A priority not taken from write");

  chk_reload_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    (inc_a && mode_a == DTC_MODE_RELOAD && cnt_a_r.lo == 8'hFF && !wr_go)
    |=> (cnt_a_r.lo == $past(cnt_a_r.hi)) && $stable(cnt_a_r.hi) && flag_a_r)
    else $error("timer A reload wrong");

  chk_split_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see R13 R23
    (split || mode_b == DTC_MODE_SPLIT) && !wr_go |=> $stable(cnt_b_r))
    else $error("timer B counted while halted");

  chk_run_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see R8
    // The split high byte runs on timer B's run bit, so it is left out here.
    (!run_a_r && !(split && run_b_r) && !wr_go) |=> $stable(cnt_a_r))
    else $error("timer A counted while stopped");

  chk_split_high: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    (inc_ah && cnt_a_r.hi == 8'hFF) |=> flag_b_r) else $error("split high overflow lost");

  chk_ack_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see R24
    (timer_a_irq_ack_i && !ovf_a && !wr_ctl) |=> !flag_a_r)
    else $error("vectoring did not clear timer A flag");

endmodule : dtc_timer_pair

// >>> dv/dtc_far_model.sv
// Far-side model: the two count pins and the processor's vectoring acknowledge.
`timescale 1ns/1ps
module dtc_far_model (
  // Clock, reset and vectoring enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ack_en_i,
  // Interrupt requests from the timers.
  input wire logic timer_a_irq_i,
  input wire logic timer_b_irq_i,
  // Count pins and vectoring pulses.
  output logic timer_a_count_pin_o,
  output logic timer_b_count_pin_o,
  output logic timer_a_irq_ack_o,
  output logic timer_b_irq_ack_o
);
  // Pins rest high, so no false edge is seen at reset release.
  logic [1:0] pin_r = 2'b11;
  assign timer_a_count_pin_o = pin_r[0];
  assign timer_b_count_pin_o = pin_r[1];

  // Three cycles low and four high per edge, well above what the synchroniser needs.
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pin_r[sel] <= 1'b0;
      repeat (3) @(posedge clk_i);
      pin_r[sel] <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulse

  // Vectoring: one acknowledge pulse per pending request, only while enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ack_en_i) begin
      timer_a_irq_ack_o <= 1'b0;
      timer_b_irq_ack_o <= 1'b0;
    end else begin
      timer_a_irq_ack_o <= timer_a_irq_i & ~timer_a_irq_ack_o;
      timer_b_irq_ack_o <= timer_b_irq_i & ~timer_b_irq_ack_o;
    end
  end
endmodule : dtc_far_model

// >>> dv/dtc_timer_pair_bench.sv
// Self-checking bench for the dual timer/counter pair.
`timescale 1ns/1ps
module dtc_timer_pair_bench;
  import dtc_pkg::*;
  // Clock, reset, bus master and far-side wires.
  logic clk_i, rst_i, cyc, stb, we, ack_en, wb_ack_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, wb_dat_o;
  logic pin_a, pin_b, ack_a, ack_b, irq_a, irq_b, pri_a, pri_b;
  int mismatches, n_tests;
  // Reset sweep offsets; the last one is unmapped.
  logic [7:0] ofs [10] = '{8'h80, 8'h84, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA8, 8'hB8, 8'h40};
  // Written offsets, the last one unmapped, and the bits that hold a written value.
  logic [7:0] wofs [5] = '{8'hA8, 8'hB8, 8'h84, 8'h8C, 8'h40};
  logic [7:0] wmsk [5] = '{8'hFF, 8'h7F, 8'h77, 8'h03, 8'h00};

  dtc_timer_pair u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_a_count_pin_i(pin_a), .timer_b_count_pin_i(pin_b),
    .timer_a_irq_ack_i(ack_a), .timer_b_irq_ack_i(ack_b),
    .timer_a_irq_o(irq_a), .timer_b_irq_o(irq_b),
    .timer_a_irq_priority_o(pri_a), .timer_b_irq_priority_o(pri_b)
  );
  dtc_far_model u_far (
    .clk_i(clk_i), .rst_i(rst_i), .ack_en_i(ack_en), .timer_a_irq_i(irq_a),
    .timer_b_irq_i(irq_b), .timer_a_count_pin_o(pin_a), .timer_b_count_pin_o(pin_b),
    .timer_a_irq_ack_o(ack_a), .timer_b_irq_ack_o(ack_b)
  );

  // Free-running 10 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or from any expired wait.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; ack and read data are taken at the rising edge where ack is
  // sampled high, and only then is the request dropped.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h1, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      test_done();
    end
    q = wb_dat_o[7:0];
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask : rd

  // Reference counter: k increments; mode-0 low bits above bit four are never counted.
  function automatic int mdl(int m, int hi, int lo, int k);
    int v;
    int f;
    f = 0;
    for (int i = 0; i < k; i++) begin
      if (m == 2) begin
        lo = (lo + 1) & 255;
        if (lo == 0) begin
          lo = hi;
          f = 1;
        end
      end else begin
        v = (m == 1) ? (hi << 8) + lo + 1 : (hi << 5) + (lo & 31) + 1;
        f = f | int'(v > ((m == 1) ? 65535 : 8191));
        hi = (m == 1) ? (v >> 8) & 255 : (v >> 5) & 255;
        lo = (m == 1) ? v & 255 : (lo & 224) | (v & 31);
      end
    end
    return (f << 16) | (hi << 8) | lo;
  endfunction : mdl

  // Watchdog against a hang anywhere in the sequence.
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int k, e, msk;
    logic [7:0] hi, lo, q, c;
    {cyc, stb, we, adr, sel, dat, ack_en} = '0;
    rst_i = 1'b1;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(32'h455c_8d48));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) begin
      rd(ofs[i], q);
      chk({8'h00, q}, 16'h0000);
    end
    foreach (wofs[i]) begin
      c = 8'($urandom());
      wr(wofs[i], c);
      rd(wofs[i], q);
      chk({8'h00, q}, {8'h00, c & wmsk[i]});
    end
    $display("test registers done");
    // Timer rate: about 120 cycles of running for each timer at each frequency select.
    for (int t = 0; t < 2; t++) begin
      for (int f = 1; f >= 0; f--) begin
        wr(8'h80, 8'h00);
        wr(8'h84, t ? 8'h10 : 8'h01);
        wr(8'h8C, 8'(f << t));
        wr(8'h90 + 8'(8 * t), 8'h00);
        wr(8'h80, 8'(16 << (2 * t)));
        repeat (120) @(posedge clk_i);
        wr(8'h80, 8'h00);
        rd(8'h90 + 8'(8 * t), q);
        k = (f == 1) ? int'(q >= 118 && q <= 126) : int'(q >= 9 && q <= 11);
        chk(16'(k), 16'h0001);
      end
    end
    $display("test rate done");
    // Pin counting in every non-split mode of both timers, near overflow.
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        k = 1 + $urandom_range(11);
        hi = (m == 2) ? 8'($urandom_range(255)) : 8'hFF;
        lo = ((m == 0) ? 8'($urandom_range(7) << 5) : 8'hE0) | 8'h18 | 8'($urandom_range(7));
        e = mdl(m, hi, lo, k);
        msk = (m == 0) ? 16'hFF1F : 16'hFFFF;
        wr(8'h80, 8'h00);
        wr(8'h84, 8'(t ? 64 + 16 * m : 4 + m));
        wr(8'h94 + 8'(8 * t), hi);
        wr(8'h90 + 8'(8 * t), lo);
        wr(8'h80, 8'(16 << (2 * t)));
        u_far.pulse(t, k);
        repeat (8) @(posedge clk_i);
        rd(8'h90 + 8'(8 * t), lo);
        rd(8'h94 + 8'(8 * t), hi);
        rd(8'h80, c);
        chk({hi, lo} & 16'(msk), 16'(e & msk));
        chk({8'h00, c}, 16'((16 << (2 * t)) | (e[16] << (5 + 2 * t))));
      end
    end
    $display("test pin counting done");
    // Split mode: low byte on pin A, high byte fast on timer B's run bit.
    wr(8'h80, 8'h00);
    wr(8'h84, 8'h57);
    wr(8'h8C, 8'h01);
    wr(8'h90, 8'h10);
    wr(8'h94, 8'hF0);
    wr(8'h98, 8'h22);
    wr(8'h9C, 8'h33);
    wr(8'h80, 8'h50);
    u_far.pulse(0, 3);
    u_far.pulse(1, 3);
    repeat (8) @(posedge clk_i);
    rd(8'h80, c);
    chk({8'h00, c}, 16'h00D0);
    rd(8'h90, q);
    chk({8'h00, q}, 16'h0013);
    rd(8'h98, lo);
    rd(8'h9C, hi);
    chk({hi, lo}, 16'h3322);
    // Timer B mode code 3 ignores its pin.
    wr(8'h80, 8'h00);
    wr(8'h84, 8'h70);
    wr(8'h80, 8'h40);
    u_far.pulse(1, 4);
    repeat (8) @(posedge clk_i);
    rd(8'h98, q);
    chk({8'h00, q}, 16'h0022);
    $display("test split done");
    // Overflow, enable gating, priority and vectoring clear.
    wr(8'h80, 8'h00);
    wr(8'h84, 8'h05);
    wr(8'h94, 8'hFF);
    wr(8'h90, 8'hFF);
    wr(8'hA8, 8'h80);
    // Software sets timer B's flag so that both enable gates are exercised.
    wr(8'hB8, 8'h0A);
    wr(8'h80, 8'h90);
    u_far.pulse(0, 1);
    repeat (8) @(posedge clk_i);
    rd(8'h80, c);
    chk({8'h00, c}, 16'h00B0);
    @(negedge clk_i);
    chk({12'h000, irq_a, irq_b, pri_a, pri_b}, 16'h0003);
    wr(8'hA8, 8'h8A);
    wr(8'hB8, 8'h02);
    @(negedge clk_i);
    chk({12'h000, irq_a, irq_b, pri_a, pri_b}, 16'h000E);
    @(posedge clk_i);
    ack_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    ack_en <= 1'b0;
    rd(8'h80, c);
    chk({8'h00, c}, 16'h0010);
    // Stopped edges are lost; running resumes from the held count.
    wr(8'h80, 8'h00);
    u_far.pulse(0, 2);
    wr(8'h80, 8'h10);
    u_far.pulse(0, 3);
    repeat (8) @(posedge clk_i);
    rd(8'h90, q);
    chk({8'h00, q}, 16'h0003);
    $display("test interrupt done");
    test_done();
  end
endmodule : dtc_timer_pair_bench
